// File: fpgp_pkg.sv
// constants and register map of the four pin gpio port
package fpgp_pkg;
  localparam int NPIN = 4;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  // register indexes; byte address is four times the index
  localparam logic [7:0] LVL_IDX = 8'h65;
  localparam logic [7:0] DIR_IDX = 8'h66;
  localparam logic [7:0] INP_IDX = 8'h67;
  localparam logic [1:0] WORD_OFS = 2'h0;
  // field positions inside the byte
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;
  localparam int BYTE_W = 8;
  localparam int BE_LANE0 = 0;
  // reset values
  localparam logic [NPIN-1:0] PIN_RST = 4'h0;
  localparam logic [NPIN-1:0] INP_RSVD = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;
  localparam logic WAIT_RST = 1'b1;
endpackage

// File: fpgp_sync_if.sv
// carrier for the synchronised pin levels
`timescale 1ns/1ps
`default_nettype none
interface fpgp_sync_if;
  logic [3:0] level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

// File: fpgp_insync.sv
// three flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module fpgp_insync
  import fpgp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [NPIN-1:0] pin_i,
  fpgp_sync_if.src sync
);
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] stable;
  logic [NPIN-1:0] next_stable;

  // s1 feeds only s2; a level counts once s2 and s3 agree
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < NPIN; i++) begin
      if (s2[i] == s3[i]) begin
        next_stable[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= PIN_RST;
      s2 <= PIN_RST;
      s3 <= PIN_RST;
      stable <= PIN_RST;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
    end
  end

  assign sync.level = stable;
endmodule
`default_nettype wire

// File: fpgp_top.sv
// four pin gpio port with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] both high and low requested for a pin: pin drives low
// [R2] a pin set as input is never driven, whatever its level bits
// [R3] one written to level bits 7..4 requests high on pins 3..0
// [R4] one written to level bits 3..0 requests low on pins 3..0
// [R5] one written to direction bits 7..4 makes pins 3..0 outputs
// [R6] one written to direction bits 3..0 makes pins 3..0 inputs
// [R7] output and input both requested for a pin: pin is input
// [R8] after reset all pins are inputs, level and direction read zero
// [R9] input register bits 7..4 return present pin levels 3..0
// [R10] input register bits 3..0 always read zero
// [R11] direction and level hold until an opposing one-write or reset
module fpgp_top
  import fpgp_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [NPIN-1:0] GENERAL_PIN_IN_I,
  output logic [NPIN-1:0] GENERAL_PIN_OUT_O,
  output logic [NPIN-1:0] GENERAL_PIN_OE_O
);

  //////////////////////////////////////////////////////////////////////////
  // types, state and helpers

  typedef enum logic {ST_IDLE, ST_ACK} fpgp_bus_t;

  fpgp_bus_t state;
  fpgp_bus_t next_state;
  logic waitreq;
  logic next_waitreq;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [NPIN-1:0] hi_req;
  logic [NPIN-1:0] lo_req;
  logic [NPIN-1:0] oe_req;
  logic [NPIN-1:0] ie_req;
  logic [NPIN-1:0] next_hi;
  logic [NPIN-1:0] next_lo;
  logic [NPIN-1:0] next_oe;
  logic [NPIN-1:0] next_ie;
  logic [NPIN-1:0] pin_out;
  logic [NPIN-1:0] pin_oe;
  logic [NPIN-1:0] next_pin_out;
  logic [NPIN-1:0] next_pin_oe;
  logic [BYTE_W-1:0] wbyte;
  logic [NPIN-1:0] wr_hi;
  logic [NPIN-1:0] wr_lo;
  logic wr_take;
  logic wr_lvl;
  logic wr_dir;
  logic rd_inp;
  // pin to filtered level: agreeing samples sit three and four edges back
  localparam int SYNC_NEAR = 3;
  localparam int SYNC_FAR = 4;

  fpgp_sync_if sync_bus ();

  fpgp_insync u_insync (
    .clk_i (CLK_SYS_I),
    .srst_i (SRST_I),
    .pin_i (GENERAL_PIN_IN_I),
    .sync (sync_bus.src)
  );

  // word aligned match of a register index
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == WORD_OFS);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, write lands on the acknowledging edge

  assign wbyte = AVS_WRITEDATA_I[BYTE_W-1:0];
  assign wr_hi = wbyte[HI_LSB +: NPIN];
  assign wr_lo = wbyte[LO_LSB +: NPIN];
  assign wr_take = (state == ST_ACK) && AVS_WRITE_I &&
                   AVS_BYTEENABLE_I[BE_LANE0];
  assign wr_lvl = wr_take && reg_hit(AVS_ADDRESS_I, LVL_IDX);
  assign wr_dir = wr_take && reg_hit(AVS_ADDRESS_I, DIR_IDX);
  assign rd_inp = (state == ST_IDLE) && AVS_READ_I &&
                  reg_hit(AVS_ADDRESS_I, INP_IDX);

  always_comb begin
    next_state = state;
    next_waitreq = WAIT_RST;
    next_rdata = rdata;
    case (state)
      ST_IDLE: begin
        if (AVS_READ_I || AVS_WRITE_I) begin
          next_state = ST_ACK;
          next_waitreq = 1'b0;
          // unmapped reads answer zero, unmapped writes are dropped
          next_rdata = RDATA_RST;
          if (AVS_READ_I) begin
            if (reg_hit(AVS_ADDRESS_I, LVL_IDX)) begin
              next_rdata[BYTE_W-1:0] = {hi_req, lo_req};
            end else if (reg_hit(AVS_ADDRESS_I, DIR_IDX)) begin
              next_rdata[BYTE_W-1:0] = {oe_req, ie_req};
            end else if (reg_hit(AVS_ADDRESS_I, INP_IDX)) begin
              next_rdata[BYTE_W-1:0] = {sync_bus.level, INP_RSVD}; // [R9] [R10]
            end
          end
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
        next_waitreq = WAIT_RST;
      end
      default: begin
        next_state = ST_IDLE;
        next_waitreq = WAIT_RST;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state <= ST_IDLE;
      waitreq <= WAIT_RST;
      rdata <= RDATA_RST;
    end else begin
      state <= next_state;
      waitreq <= next_waitreq;
      rdata <= next_rdata;
    end
  end

  assign AVS_READDATA_O = rdata;
  assign AVS_WAITREQUEST_O = waitreq;

  //////////////////////////////////////////////////////////////////////////
  // pin state: set and clear halves, the opposing one-write clears

  always_comb begin
    next_hi = hi_req;
    next_lo = lo_req;
    next_oe = oe_req;
    next_ie = ie_req;
    if (wr_lvl) begin
      next_hi = (hi_req & ~wr_lo) | wr_hi; // [R3] [R11]
      next_lo = (lo_req & ~wr_hi) | wr_lo; // [R4] [R11]
    end
    if (wr_dir) begin
      next_oe = (oe_req & ~wr_lo) | wr_hi; // [R5] [R11]
      next_ie = (ie_req & ~wr_hi) | wr_lo; // [R6] [R11]
    end
    // pins follow the new state on the same edge as the write
    next_pin_oe = next_oe & ~next_ie; // [R7]
    next_pin_out = next_hi & ~next_lo & next_pin_oe; // [R1] [R2]
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      hi_req <= PIN_RST; // [R8]
      lo_req <= PIN_RST;
      oe_req <= PIN_RST;
      ie_req <= PIN_RST;
      pin_out <= PIN_RST;
      pin_oe <= PIN_RST;
    end else begin
      hi_req <= next_hi;
      lo_req <= next_lo;
      oe_req <= next_oe;
      ie_req <= next_ie;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // undriven pins still show low on the out lines, so no glitch on enable
  assign GENERAL_PIN_OUT_O = pin_out;
  assign GENERAL_PIN_OE_O = pin_oe;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SRST_I);

  low_wins_a: assert property ( // [R1]
    (pin_out & lo_req) == PIN_RST)
    else $error("pin driven high while low is requested");

  input_undriven_a: assert property ( // [R2]
    (pin_out & ~pin_oe) == PIN_RST)
    else $error("pin set as input shows drive level");

  set_high_a: assert property ( // [R3]
    wr_lvl |=> ((($past(wr_hi) & ~$past(wr_lo)) & ~GENERAL_PIN_OUT_O &
                 pin_oe) == PIN_RST) &&
               ((($past(wr_hi) & ~$past(wr_lo)) & ~hi_req) == PIN_RST))
    else $error("high request not taken");

  set_low_a: assert property ( // [R4]
    wr_lvl |=> (($past(wr_lo) & GENERAL_PIN_OUT_O) == PIN_RST) &&
               (($past(wr_lo) & ~lo_req) == PIN_RST))
    else $error("low request not taken");

  dir_output_a: assert property ( // [R5]
    wr_dir |=> (($past(wr_hi) & ~$past(wr_lo) & ~GENERAL_PIN_OE_O) ==
                PIN_RST))
    else $error("output direction not taken");

  dir_input_a: assert property ( // [R6]
    wr_dir |=> (($past(wr_lo) & GENERAL_PIN_OE_O) == PIN_RST))
    else $error("input direction not taken");

  input_wins_a: assert property ( // [R7]
    (oe_req & ie_req & pin_oe) == PIN_RST)
    else $error("pin driven while input requested");

  reset_state_a: assert property ( // [R8]
    @(posedge CLK_SYS_I) disable iff (1'b0)
    !SRST_I && $past(SRST_I) |-> (GENERAL_PIN_OE_O == PIN_RST) &&
    ({hi_req, lo_req, oe_req, ie_req} == {4{PIN_RST}}))
    else $error("state not cleared by reset");

  input_read_a: assert property ( // [R9]
    rd_inp |=> !AVS_WAITREQUEST_O &&
               (AVS_READDATA_O[HI_LSB +: NPIN] == $past(sync_bus.level)))
    else $error("input read returns wrong pin levels");

  input_rsvd_a: assert property ( // [R10]
    rd_inp |=> (AVS_READDATA_O[LO_LSB +: NPIN] == INP_RSVD))
    else $error("reserved input bits not zero");

  hold_state_a: assert property ( // [R11]
    !wr_lvl && !wr_dir |=> $stable(hi_req) && $stable(lo_req) &&
                          $stable(oe_req) && $stable(ie_req))
    else $error("pin state changed without a write");

  bus_answer_a: assert property (
    (state == ST_IDLE) && (AVS_READ_I || AVS_WRITE_I) |=>
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer not one wait cycle");

  reset_bus_a: assert property ( // [R8]
    @(posedge CLK_SYS_I) disable iff (1'b0)
    !SRST_I && $past(SRST_I) |-> AVS_WAITREQUEST_O &&
    (AVS_READDATA_O == RDATA_RST))
    else $error("bus outputs not cleared by reset");

  idle_wait_a: assert property (
    (state == ST_IDLE) |-> AVS_WAITREQUEST_O)
    else $error("waitrequest low while idle");

  rdata_upper_a: assert property (
    AVS_READDATA_O[DATA_W-1:BYTE_W] == RDATA_RST[DATA_W-1:BYTE_W])
    else $error("read data upper bytes not zero");

  unmapped_read_a: assert property (
    (state == ST_IDLE) && AVS_READ_I && !reg_hit(AVS_ADDRESS_I, LVL_IDX) &&
    !reg_hit(AVS_ADDRESS_I, DIR_IDX) && !rd_inp |=>
    (AVS_READDATA_O == RDATA_RST))
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (
    (state == ST_IDLE) && !AVS_READ_I && !AVS_WRITE_I |=>
    $stable(AVS_READDATA_O))
    else $error("read data moved without a request");

  lvl_read_a: assert property ( // [R11]
    (state == ST_IDLE) && AVS_READ_I && reg_hit(AVS_ADDRESS_I, LVL_IDX) |=>
    (AVS_READDATA_O[BYTE_W-1:0] == {$past(hi_req), $past(lo_req)}))
    else $error("level readback differs from stored requests");

  dir_read_a: assert property ( // [R11]
    (state == ST_IDLE) && AVS_READ_I && reg_hit(AVS_ADDRESS_I, DIR_IDX) |=>
    (AVS_READDATA_O[BYTE_W-1:0] == {$past(oe_req), $past(ie_req)}))
    else $error("direction readback differs from stored requests");

  lane_off_a: assert property ( // [R11]
    (state == ST_ACK) && AVS_WRITE_I && !AVS_BYTEENABLE_I[BE_LANE0] |=>
    $stable(hi_req) && $stable(lo_req) && $stable(oe_req) && $stable(ie_req))
    else $error("write with lane zero off changed pin state");

  idle_no_write_a: assert property ( // [R11]
    (state == ST_IDLE) |=> $stable(hi_req) && $stable(lo_req) &&
                           $stable(oe_req) && $stable(ie_req))
    else $error("pin state changed outside the answer edge");

  pins_hold_a: assert property ( // [R11]
    !wr_lvl && !wr_dir |=> $stable(GENERAL_PIN_OUT_O) &&
                          $stable(GENERAL_PIN_OE_O))
    else $error("pins moved without a write");

  sync_follow_a: assert property ( // [R9]
    !$past(SRST_I) |->
    (((sync_bus.level ^ $past(sync_bus.level)) &
      (sync_bus.level ^ $past(GENERAL_PIN_IN_I, SYNC_NEAR))) == PIN_RST) &&
    (((sync_bus.level ^ $past(sync_bus.level)) &
      (sync_bus.level ^ $past(GENERAL_PIN_IN_I, SYNC_FAR))) == PIN_RST))
    else $error("filtered pin level not two agreeing samples");

  drive_high_c: cover property (wr_lvl ##1 (GENERAL_PIN_OUT_O != PIN_RST));
  dir_both_c: cover property (wr_dir && ((wr_hi & wr_lo) != PIN_RST));
  input_read_c: cover property (rd_inp ##1 !AVS_WAITREQUEST_O);
  level_both_c: cover property (wr_lvl && ((wr_hi & wr_lo) != PIN_RST));
  dir_out_c: cover property (wr_dir ##1 (GENERAL_PIN_OE_O != PIN_RST));
endmodule
`default_nettype wire

// File: fpgp_board.sv
// board side model of the four general pins
`timescale 1ns/1ps
`default_nettype none
module fpgp_board (
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] ext_i,
  output logic [3:0] level_o
);
  // an undriven pin follows the board's own level, never the last drive
  assign level_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule
`default_nettype wire

// File: four_pin_gpio_port_tb_top.sv
// self-checking bench for the four pin gpio port
`timescale 1ns/1ps
`default_nettype none
module four_pin_gpio_port_tb_top;
  import fpgp_pkg::*;
  localparam logic [9:0] A_LVL = {LVL_IDX, WORD_OFS};
  localparam logic [9:0] A_DIR = {DIR_IDX, WORD_OFS};
  localparam logic [9:0] A_INP = {INP_IDX, WORD_OFS};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0] be = 4'h0;
  logic [DATA_W-1:0] rdata;
  logic waitreq;
  logic [3:0] pout, poe, plevel;
  logic [3:0] ext = 4'h0;
  logic [3:0] hi = 4'h0, lo = 4'h0, oe = 4'h0, ie = 4'h0;
  logic [7:0] rnd = 8'h54;
  logic [31:0] q;
  int n_fail = 0;
  int num_checks = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  fpgp_top u_dut (.CLK_SYS_I(clk), .SRST_I(srst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .GENERAL_PIN_IN_I(plevel),
    .GENERAL_PIN_OUT_O(pout), .GENERAL_PIN_OE_O(poe));
  fpgp_board u_board (.out_i(pout), .oe_i(poe), .ext_i(ext),
    .level_o(plevel));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [3:0] exp_oe();
    exp_oe = oe & ~ie;
  endfunction
  function automatic logic [3:0] exp_out();
    exp_out = hi & ~lo & exp_oe();
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    // hold until waitrequest is seen low at a rising edge; watchdog ends a hang
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk_pins;
    @(negedge clk);
    chk("pin oe", {28'h0, poe}, {28'h0, exp_oe()});
    chk("pin out", {28'h0, pout}, {28'h0, exp_out()});
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] b);
    bus(1'b1, a, d, b);
    // model applies only enabled writes to mapped registers
    if (b[0] && a == A_LVL) begin
      hi = d[7:4] | (hi & ~d[3:0]);
      lo = d[3:0] | (lo & ~d[7:4]);
    end
    if (b[0] && a == A_DIR) begin
      oe = d[7:4] | (oe & ~d[3:0]);
      ie = d[3:0] | (ie & ~d[7:4]);
    end
    chk_pins();
  endtask
  task automatic chk_regs;
    bus(1'b0, A_LVL, 8'h00, 4'hF);
    chk("level reg", q, {24'h0, hi, lo});
    bus(1'b0, A_DIR, 8'h00, 4'hF);
    chk("dir reg", q, {24'h0, oe, ie});
    repeat (6) @(posedge clk);
    bus(1'b0, A_INP, 8'h00, 4'hF);
    chk("input reg", q, {24'h0, exp_out() | (ext & ~exp_oe()),
                         4'h0});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    chk_pins();
    chk_regs();
    wreg(A_DIR, 8'hF0, 4'h1);
    wreg(A_LVL, 8'hFF, 4'h1);
    wreg(A_LVL, 8'hA0, 4'h1);
    wreg(A_LVL, 8'h0F, 4'hE);
    wreg(A_DIR, 8'hFF, 4'h1);
    wreg(10'h1A0, 8'hFF, 4'h1);
    bus(1'b0, 10'h1A0, 8'h00, 4'hF);
    chk("unmapped", q, 32'h0000_0000);
    chk_regs();
    // random writes with occasional disabled lane and moving board levels
    repeat (80) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      ext <= rnd[3:0];
      rnd = lfsr(rnd);
      wreg(rnd[7] ? A_DIR : A_LVL, lfsr(rnd), {3'h0, |rnd[2:1]});
      rnd = lfsr(rnd);
      chk_regs();
    end
    // mid-run reset must clear requests and pins again
    @(posedge clk);
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    hi = 4'h0;
    lo = 4'h0;
    oe = 4'h0;
    ie = 4'h0;
    chk_pins();
    chk_regs();
    conclude();
  end
endmodule
`default_nettype wire
